// *** rtl/watchdog_pkg.sv ***
package watchdog_pkg;

  // register map, as byte addresses of the 8-bit register port
  localparam logic [7:0] CONFIG_ADDR  = 8'h34;
  localparam logic [7:0] COMMAND_ADDR = 8'h35;

  // field positions of watchdog_config
  localparam int unsigned RAM_TRAP_BIT  = 5;
  localparam int unsigned TRAP_ACT_BIT  = 4;
  localparam int unsigned ENABLE_BIT    = 3;
  localparam int unsigned TIME_SEL_HI   = 2;
  localparam int unsigned TIME_SEL_LO   = 1;
  localparam int unsigned ACTION_BIT    = 0;

  // reset values
  localparam logic       ENABLE_RST    = 1'b1;
  localparam logic [1:0] TIME_SEL_RST  = 2'h0;
  localparam logic       ACTION_RST    = 1'b1;
  localparam logic [1:0] BIN_CNT_RST   = 2'h0;

  // command codes
  localparam logic [7:0] CODE_CLEAR    = 8'h4E;
  localparam logic [7:0] CODE_DISABLE  = 8'hB1;
  localparam logic [7:0] CODE_TRAP     = 8'hD2;

  // divider exponents for a quarter of the detection time, code 00
  localparam int unsigned FAST_QTR_EXP = 23;
  localparam int unsigned SLOW_QTR_EXP = 15;
  localparam int unsigned DIV_WIDTH    = 24;

  // reset pulse: at most 24 fast clock periods
  localparam int unsigned RESET_MAX_FC = 24;

  // decoded write
  typedef struct packed {
    logic       wr_config;
    logic       wr_command;
    logic [7:0] data;
  } reg_write_t;

  // watchdog reset pulse sequencer states
  typedef enum logic [0:0] {
    RST_IDLE  = 1'b0,
    RST_PULSE = 1'b1
  } rst_state_t;

endpackage : watchdog_pkg

// *** rtl/watchdog_timer_control.sv ***
// What the document asks of this block and of its software
// (R1) enable bit comes out of reset set, counting starts at once
// (R2) overflow with action bit 1 asserts reset request and drives reset low
// (R3) overflow with action bit 0 raises the watchdog interrupt request
// (R4) stop, idle and sleep freeze the count; it resumes afterwards
// (R5) clear code 4EH clears only the binary counter, not the divider
// (R6) software clears within three quarters of the detection time
// (R7) two-bit field selects 2^25..2^19 fast or 2^17..2^11 slow periods
// (R8) once action bit is 0 it cannot return to 1 until reset
// (R9) config register is write only, reads return don't care
// (R10) command codes 4EH clear, B1H disable, D2H trap commit; others ignored
// (R11) disable code acts only while enable bit already holds 0
// (R12) software stops it: master flag off, clear, enable 0, then B1H
// (R13) while disabled the binary counter is held cleared
// (R14) watchdog interrupt is non-maskable, ignores interrupt master flag
// (R15) new watchdog interrupt is taken at once, even while one is serviced
// (R16) software sets the stack pointer before choosing interrupt mode
// (R17) watchdog reset lasts at most 24 fast clock periods
// (R18) software disables or clears before stop, clears again after
// (R19) software does not clear the counter from an interrupt routine
// (R20) counter advances each quarter detection time; overflow on fourth tick
// (R21) divider source bit picks fast chain (0) or slow chain (1); here low-speed mode forces the slow chain whatever the bit
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_control
  import watchdog_pkg::*;
#(
  parameter int unsigned DIV_W = DIV_WIDTH
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  // timing sources and power modes (from pins or other clock domains)
  input  wire logic       fast_tick,
  input  wire logic       slow_tick,
  input  wire logic       divider_source_select,
  input  wire logic       low_speed_mode,
  input  wire logic       freeze_mode,
  // outputs
  output logic            watchdog_irq,
  output logic            reset_request,
  output logic            reset_pin_n,
  output logic            reset_pin_oe_n,
  output logic            ram_trap_select,
  output logic            trap_action_select,
  output logic            trap_commit
);
  import watchdog_pkg::*;

  // decode of one register write; shared by config and command paths
  function automatic reg_write_t decode_write(input logic [7:0] a,
                                              input logic       s,
                                              input logic [7:0] d);
    reg_write_t w;
    w.wr_config  = s && (a == CONFIG_ADDR);
    w.wr_command = s && (a == COMMAND_ADDR);
    w.data       = d;
    return w;
  endfunction : decode_write

  reg_write_t wr;
  assign wr = decode_write(addr, wr_stb, wdata);

  // two-flop synchronisers for inputs from outside this clock domain
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {fast_tick, slow_tick, divider_source_select,
                  low_speed_mode, freeze_mode};
      sync2_q <= sync1_q;
    end
  end

  logic fast_s;
  logic slow_s;
  logic src_s;
  logic lowspd_s;
  logic freeze_s;
  assign {fast_s, slow_s, src_s, lowspd_s, freeze_s} = sync2_q;

  // edge detect on the synchronised clock-source levels
  logic fast_prev_q;
  logic slow_prev_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fast_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      fast_prev_q <= fast_s;
      slow_prev_q <= slow_s;
    end
  end

  logic fast_rise;
  logic slow_rise;
  assign fast_rise = fast_s && !fast_prev_q;
  assign slow_rise = slow_s && !slow_prev_q;

  // source: slow chain in low-speed mode or when selected
  logic use_slow;
  logic src_rise;
  assign use_slow = lowspd_s || src_s; // R21 R7
  assign src_rise = use_slow ? slow_rise : fast_rise;

  // configuration register (write only)
  logic       enable_q;
  logic [1:0] time_sel_q;
  logic       action_q;
  logic       ram_trap_q;
  logic       trap_act_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      enable_q   <= ENABLE_RST; // R1
      time_sel_q <= TIME_SEL_RST;
      action_q   <= ACTION_RST;
      ram_trap_q <= 1'b0;
      trap_act_q <= 1'b1;
    end else if (wr.wr_config) begin
      enable_q   <= wr.data[ENABLE_BIT];
      time_sel_q <= wr.data[TIME_SEL_HI:TIME_SEL_LO];
      // once cleared, the action bit sticks at interrupt
      action_q   <= action_q & wr.data[ACTION_BIT]; // R8
      ram_trap_q <= wr.data[RAM_TRAP_BIT];
      trap_act_q <= wr.data[TRAP_ACT_BIT];
    end
  end

  // command decode
  logic cmd_clear;
  logic cmd_disable;
  logic cmd_trap;
  assign cmd_clear   = wr.wr_command && (wr.data == CODE_CLEAR);   // R10
  assign cmd_disable = wr.wr_command && (wr.data == CODE_DISABLE)
                       && !enable_q;                               // R10 R11
  assign cmd_trap    = wr.wr_command && (wr.data == CODE_TRAP);    // R10

  // running state: enable bit alone cannot stop it; disable code must follow
  logic running_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      running_q <= 1'b1; // R1
    end else if (cmd_disable) begin
      running_q <= 1'b0; // R11
    end else if (wr.wr_config && wr.data[ENABLE_BIT]) begin
      running_q <= 1'b1;
    end
  end

  // free-running divider; never cleared by the clear code
  logic [DIV_W-1:0] div_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_q <= '0;
    end else if (src_rise && !freeze_s) begin
      div_q <= div_q + DIV_W'(1); // R4 R5
    end
  end

  // quarter-period tap: exponent shrinks by two per code step
  function automatic int unsigned tap_index(input logic [1:0] sel,
                                            input logic       slow);
    int unsigned base;
    base = slow ? SLOW_QTR_EXP : FAST_QTR_EXP;
    return base - 2 * int'(sel) - 1;
  endfunction : tap_index

  logic tap_q;
  logic tap_now;
  assign tap_now = div_q[tap_index(time_sel_q, use_slow)];
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tap_q <= 1'b0;
    end else begin
      tap_q <= tap_now;
    end
  end

  // quarter tick on the falling edge of the selected tap
  logic qtick;
  assign qtick = tap_q && !tap_now && !freeze_s; // R20 R4

  // two-stage binary counter; overflow on the fourth quarter tick
  logic [1:0] bin_q;
  logic       overflow;
  // a clear in the same cycle wins over the tick, so no overflow either
  assign overflow = running_q && qtick && !cmd_clear
                    && (bin_q == 2'h3); // R20 R5
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bin_q <= BIN_CNT_RST;
    end else if (!running_q || cmd_clear) begin
      bin_q <= BIN_CNT_RST; // R5 R13
    end else if (qtick) begin
      bin_q <= bin_q + 2'h1;
    end
  end

  // interrupt: a one-cycle pulse per overflow, never gated by any mask
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      watchdog_irq <= 1'b0;
    end else begin
      watchdog_irq <= overflow && !action_q; // R3 R14 R15
    end
  end

  // reset pulse in mclk cycles; mclk never runs slower than the fast clock
  localparam int unsigned RST_CYC = RESET_MAX_FC;
  rst_state_t       rst_state_q;
  logic       [4:0] rst_cnt_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rst_state_q <= RST_IDLE;
      rst_cnt_q   <= 5'h00;
    end else begin
      unique case (rst_state_q)
        RST_IDLE: begin
          if (overflow && action_q) begin
            rst_state_q <= RST_PULSE; // R2
            rst_cnt_q   <= 5'(RST_CYC - 1);
          end
        end
        RST_PULSE: begin
          if (rst_cnt_q == 5'h00) begin
            rst_state_q <= RST_IDLE; // R17
          end else begin
            rst_cnt_q <= rst_cnt_q - 5'h01;
          end
        end
      endcase
    end
  end

  // reset pin is driven low only during the pulse (open drain)
  assign reset_request  = (rst_state_q == RST_PULSE); // R2
  assign reset_pin_n    = 1'b0;
  assign reset_pin_oe_n = !reset_request;

  // address-trap settings are handed on to the trap logic
  assign ram_trap_select    = ram_trap_q;
  assign trap_action_select = trap_act_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      trap_commit <= 1'b0;
    end else begin
      trap_commit <= cmd_trap; // R10
    end
  end

  // both registers are write only; read data is zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= 8'h00; // R9
    end
  end

  // checks
  AST_R2_PULSE: assert property (@(posedge mclk) disable iff (!nrst) // R2
    (overflow && action_q) |=> reset_request && !reset_pin_oe_n)
    else $error("reset did not start after overflow");
  AST_R3_IRQ: assert property (@(posedge mclk) disable iff (!nrst) // R3
    (overflow && !action_q) |=> watchdog_irq && !reset_request)
    else $error("interrupt missing after overflow");
  AST_R8_STICKY: assert property (@(posedge mclk) disable iff (!nrst) // R8
    !action_q |=> !action_q)
    else $error("action bit returned to reset");
  AST_R11_IGNORE: assert property (@(posedge mclk) disable iff (!nrst) // R11
    (wr.wr_command && wr.data == CODE_DISABLE && enable_q && running_q)
    |=> running_q)
    else $error("disable code acted while enabled");
  AST_R13_HELD: assert property (@(posedge mclk) disable iff (!nrst) // R13
    !running_q |=> bin_q == 2'h0)
    else $error("counter moved while disabled");
  AST_R5_CLEAR: assert property (@(posedge mclk) disable iff (!nrst) // R5
    cmd_clear |=> bin_q == 2'h0
    && (div_q == $past(div_q) || div_q == $past(div_q) + DIV_W'(1)))
    else $error("clear code touched more than the counter");
  AST_R4_FREEZE: assert property (@(posedge mclk) disable iff (!nrst) // R4
    (freeze_s && !cmd_clear && running_q) |=> $stable(bin_q))
    else $error("counter moved while frozen");
  AST_R17_LEN: assert property (@(posedge mclk) disable iff (!nrst) // R17
    $rose(reset_request) |-> ##24 !reset_request)
    else $error("reset pulse too long");
  AST_R1_START: assert property (@(posedge mclk) // R1
    !nrst |=> running_q && enable_q && action_q)
    else $error("not enabled after reset");

  // the disable code with the enable bit already low must stop counting
  AST_R11_DISABLE: assert property (@(posedge mclk) disable iff (!nrst) // R11
    (wr.wr_command && wr.data == CODE_DISABLE && !enable_q) |=> !running_q)
    else $error("disable code ignored while enable bit low");

  // divider stands still while frozen, so its phase resumes intact
  AST_R4_DIV: assert property (@(posedge mclk) disable iff (!nrst) // R4
    freeze_s |=> $stable(div_q))
    else $error("divider moved while frozen");

  // every quarter tick while running and not cleared moves the counter by exactly one
  AST_R20_STEP: assert property (@(posedge mclk) disable iff (!nrst) // R20
    (running_q && qtick && !cmd_clear)
    |=> bin_q == $past(bin_q) + 2'h1)
    else $error("counter did not step on a quarter tick");

  // one overflow gives one interrupt cycle, never a held level
  AST_R15_PULSE: assert property (@(posedge mclk) disable iff (!nrst) // R15
    watchdog_irq |=> !watchdog_irq)
    else $error("interrupt held longer than one cycle");

  // pin stays driven low until the pulse counter has run out
  AST_R17_HOLD: assert property (@(posedge mclk) disable iff (!nrst) // R17
    (reset_request && rst_cnt_q != 5'h00) |=> reset_request)
    else $error("reset pulse ended early");

  // only the trap code pulses the commit line; codes other than clear keep the count
  AST_R10_TRAP: assert property (@(posedge mclk) disable iff (!nrst) // R10
    (wr_stb && addr == COMMAND_ADDR && wdata == CODE_TRAP) |=> trap_commit)
    else $error("trap commit missing");
  AST_R10_OTHER: assert property (@(posedge mclk) disable iff (!nrst) // R10
    !(wr_stb && addr == COMMAND_ADDR && wdata == CODE_TRAP) |=> !trap_commit)
    else $error("trap commit without its code");
  AST_R10_KEEP: assert property (@(posedge mclk) disable iff (!nrst) // R10
    (wr.wr_command && wr.data != CODE_CLEAR && running_q && !qtick)
    |=> $stable(bin_q))
    else $error("command other than clear moved the counter");

  // reads of the write-only places see zero in the following cycle
  AST_R9_READ: assert property (@(posedge mclk) disable iff (!nrst) // R9
    rd_stb |=> rdata == 8'h00)
    else $error("read data not zero");

endmodule : watchdog_timer_control

`default_nettype wire

// *** verif/cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// software side of the register port, one access per call
module cpu_model (
  // clock
  input  wire logic       mclk,
  // register port
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_stb,
  output logic            rd_stb
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // one-cycle strobe, then an idle edge so calls never collide
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= w;
    rd_stb <= ~w;
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
  endtask : acc
endmodule : cpu_model

`default_nettype wire

// *** verif/tb_watchdog_timer_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_watchdog_timer_control;
  import watchdog_pkg::*;
  // full period: four quarters of 512 slow ticks, 4 mclk each
  localparam int QT = 8192;
  logic       mclk, nrst, fast_tick, slow_tick, src, lsm, frz;
  logic [1:0] sdiv;
  logic [7:0] addr, wdata, rdata, a, c, t;
  logic       wr_stb, rd_stb, irq, rreq, pin_n, oe_n, rts, tas, tcm;
  logic       rd_seen, rreq_q;
  logic [7:0] evq[$], rdq[$];
  logic [31:0] seed;
  int         err_count, tests_run, width, gap, last_gap, i;

  cpu_model cpu_model_i (.mclk(mclk), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb));

  watchdog_timer_control #(.DIV_W(DIV_WIDTH)) watchdog_timer_control_i (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .fast_tick(fast_tick), .slow_tick(slow_tick),
    .divider_source_select(src), .low_speed_mode(lsm),
    .freeze_mode(frz), .watchdog_irq(irq), .reset_request(rreq),
    .reset_pin_n(pin_n), .reset_pin_oe_n(oe_n),
    .ram_trap_select(rts), .trap_action_select(tas), .trap_commit(tcm));

  always #2.5 mclk = ~mclk;

  // slow source at a 4-cycle period so the synchroniser never misses it
  always @(posedge mclk) begin
    fast_tick <= ~fast_tick;
    sdiv      <= sdiv + 2'h1;
    slow_tick <= sdiv[1];
  end

  task automatic bad(input string m);
    err_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : bad

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) bad(m);
  endtask : chk

  task automatic summarize;
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic ev(input logic [7:0] k);
    if (evq.size() == 0) bad("unexpected event");
    else chk(evq.pop_front() === k, "event kind");
  endtask : ev

  task automatic drain(input int n);
    for (int j = 0; j < n && evq.size() > 0; j++) @(posedge mclk);
    @(posedge mclk);
    if (evq.size() > 0) begin
      bad("event missing");
      summarize();
    end
  endtask : drain

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
  endtask : do_reset

  task automatic wr(input logic [7:0] ad, d);
    cpu_model_i.acc(1'b1, ad, d);
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    rdq.push_back(8'h00);
    cpu_model_i.acc(1'b0, ad, 8'h00);
  endtask : rd

  // monitor: each result retires the oldest note
  always @(posedge mclk) begin
    rd_seen <= rd_stb;
    rreq_q  <= rreq;
    gap     <= gap + 1;
    if (rd_seen === 1'b1) begin
      if (rdq.size() == 0) bad("stray read");
      else chk(rdata === rdq.pop_front(), "read data");
    end
    if (irq === 1'b1) begin
      gap      <= 1;
      last_gap <= gap;
      ev(8'h01);
    end
    if (rreq === 1'b1) begin
      width <= width + 1;
      chk(oe_n === 1'b0 && pin_n === 1'b0, "reset pin");
    end else if (nrst === 1'b1) begin
      chk(oe_n === 1'b1, "reset pin released");
    end
    if (rreq === 1'b1 && rreq_q !== 1'b1) ev(8'h02);
    if (rreq !== 1'b1 && rreq_q === 1'b1) begin
      chk(width == RESET_MAX_FC, "reset length");
      width <= 0;
    end
    if (tcm === 1'b1) ev(8'h03);
  end

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    fast_tick = 1'b0;
    slow_tick = 1'b0;
    sdiv = 2'h0;
    src = 1'b1;
    lsm = 1'b0;
    frz = 1'b0;
    seed = 32'h7808F734;
    rd_seen = 1'b0;
    rreq_q = 1'b0;
    width = 0;
    gap = 0;
    err_count = 0;
    tests_run = 0;
    do_reset();
    // write-only places and an unmapped one read as zero
    rd(CONFIG_ADDR);
    rd(COMMAND_ADDR);
    a = rnd();
    if (a == CONFIG_ADDR || a == COMMAND_ADDR) a = 8'h00;
    rd(a);
    // interrupt mode; enable 0 without the disable code keeps counting
    t = rnd() & 8'h30;
    wr(CONFIG_ADDR, t | 8'h06);
    wr(CONFIG_ADDR, t | 8'h07);
    chk(rts === t[5] && tas === t[4], "trap bits");
    evq.push_back(8'h01);
    evq.push_back(8'h01);
    drain(2 * QT + 200);
    chk(last_gap == QT, "overflow period");
    // clears at half the period keep the overflow away
    repeat (3) begin
      wr(COMMAND_ADDR, CODE_CLEAR);
      repeat (QT / 2) @(posedge mclk);
    end
    // codes outside the set, and disable while enabled, do nothing
    for (i = 0; i < 6; i++) begin
      c = rnd();
      if (c == CODE_CLEAR || c == CODE_DISABLE || c == CODE_TRAP) c ^= 8'h01;
      wr(COMMAND_ADDR, c);
    end
    wr(CONFIG_ADDR, t | 8'h0E);
    wr(COMMAND_ADDR, CODE_DISABLE);
    evq.push_back(8'h03);
    wr(COMMAND_ADDR, CODE_TRAP);
    drain(10);
    // freeze holds the count, counting goes on afterwards
    wr(COMMAND_ADDR, CODE_CLEAR);
    frz <= 1'b1;
    repeat (QT + 800) @(posedge mclk);
    frz <= 1'b0;
    evq.push_back(8'h01);
    drain(QT + 200);
    // proper stop sequence, then silence for over a period
    wr(COMMAND_ADDR, CODE_CLEAR);
    wr(CONFIG_ADDR, t | 8'h06);
    wr(COMMAND_ADDR, CODE_DISABLE);
    // random modes and sources while disabled must never wake it
    for (i = 0; i < QT + 800; i++) begin
      c = rnd();
      frz <= c[0];
      lsm <= c[1];
      src <= c[2];
      @(posedge mclk);
    end
    frz <= 1'b0;
    lsm <= 1'b0;
    // fast chain is far too slow to overflow within this wait
    src <= 1'b0;
    wr(CONFIG_ADDR, t | 8'h0E);
    repeat (QT + 800) @(posedge mclk);
    lsm <= 1'b1;
    evq.push_back(8'h01);
    drain(QT + 800);
    // second reset in mid-run, then reset-mode overflow
    lsm <= 1'b0;
    src <= 1'b1;
    do_reset();
    wr(CONFIG_ADDR, 8'h0F);
    evq.push_back(8'h02);
    drain(QT + 800);
    repeat (40) @(posedge mclk);
    summarize();
  end
endmodule : tb_watchdog_timer_control

`default_nettype wire
